//--- logic/eed_defines.svh
// eed_defines.svh: offsets, field positions, reset values and timing counts
// for the echo envelope decimator; included by the decimator top only.
`ifndef EED_DEFINES_SVH
`define EED_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define EED_OFS_RATIO 4'h0
`define EED_OFS_CTRL 4'h1
`define EED_OFS_NUM 4'h2
`define EED_OFS_FB 4'h3
`define EED_OFS_STATUS 4'h4
`define EED_OFS_LAST 4'h5
`define EED_OFS_PEAK 4'h6

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define EED_CTRL_FILT_BIT 0
`define EED_STAT_OVR_BIT 0
`define EED_STAT_BUSY_BIT 1
`define EED_RATIO_RST 6'h19
`define EED_NUM_RST 16'h04D7
`define EED_FB_RST 16'h7652
`define EED_COEF_FRAC 15

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define EED_CLK_PERIOD_NS 10
`define EED_SAMPLE_PERIOD_US 1
`define EED_SAMPLE_CYCLES ((`EED_SAMPLE_PERIOD_US * 1000) / `EED_CLK_PERIOD_NS)

`endif

//--- logic/eed_pkg.sv
// eed_pkg.sv: types shared by the echo envelope decimator.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package eed_pkg;

	// gray coded along idle -> calc -> push
	typedef enum logic [1:0]
	{
		EED_IDLE = 2'b00,
		EED_CALC = 2'b01,
		EED_PUSH = 2'b11
	} eed_state_t;

endpackage

`default_nettype wire

//--- logic/eed_fifo.sv
// eed_fifo.sv: flip-flop fifo with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module eed_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// fill level
	output logic [$clog2(DEPTH+1)-1:0] level_o
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_q != CW'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_q[rd_q];
	assign level_o = cnt_q;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
	endfunction

	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= bump(wr_q);
			if (pop)
				rd_q <= bump(rd_q);
			if (push && !pop)
				cnt_q <= cnt_q + CW'(1);
			else if (pop && !push)
				cnt_q <= cnt_q - CW'(1);
		end
	end

endmodule

`default_nettype wire

//--- logic/eed_decimator.sv
// eed_decimator.sv: rectifier, peak extractor, decimator and optional
// first-order low-pass filter in front of a 16-word output fifo.
// assumes the band-pass result is held steady between sample ticks.
//
// How it works
// - emits peak clear pulse and decimated samples
// - six-bit ratio, any value 1..63 accepted
// - up-counter from zero, one step per sample
// - at ratio: counter to zero, clear pulse
// - clear forces held peak value to zero
// - one output every ratio microseconds
// - decimated samples optionally low-pass filtered
// - first-order recursive filter, programmable cutoff
// - numerator and feedback coefficients set cutoff
// - peak updates only when input exceeds it
// - peak input is rectified band-pass magnitude
`include "eed_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module eed_decimator #(
	parameter int DW = 16,
	parameter int FIFO_DEPTH = 16,
	parameter int SAMPLE_CYCLES = `EED_SAMPLE_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// band-pass result, signed
	input wire logic signed [DW-1:0] bp_sample_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DW-1:0] reg_rdata_o,
	// peak extractor clear
	output logic clear_o,
	// fifo drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [DW-1:0] out_data_o
);

	localparam int TW = $clog2(SAMPLE_CYCLES);
	localparam int LW = $clog2(FIFO_DEPTH+1);
	localparam int AW = 2*DW+3;

	// ----------------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------------
	logic [5:0] ratio_q;
	logic filt_en_q;
	logic [DW-1:0] lowpass_numerator_coeff_q;
	logic [DW-1:0] lowpass_feedback_coeff_q;
	logic ovr_q;
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] last_q;
	logic [LW-1:0] level;

	// ----------------------------------------------------------------------
	// datapath state
	// ----------------------------------------------------------------------
	logic [TW-1:0] tick_cnt_q;
	logic tick;
	logic [5:0] cnt_q;
	logic wrap;
	logic [DW-1:0] mag;
	logic [DW-1:0] peak_q;
	logic [DW-1:0] dec_max;
	logic clear_q;
	logic dec_valid_q;
	logic [DW-1:0] dec_q;
	logic [DW-1:0] x_prev_q;
	logic [DW-1:0] y_q;
	logic [DW-1:0] push_data_q;
	eed_pkg::eed_state_t st_q;
	logic push_ready;

	function automatic logic [DW-1:0] rectify(input logic signed [DW-1:0] v);
		return v[DW-1] ? DW'(-v) : DW'(v);
	endfunction

	function automatic logic [DW-1:0] iir(input logic [DW-1:0] x,
		input logic [DW-1:0] xp, input logic [DW-1:0] yp,
		input logic [DW-1:0] b, input logic [DW-1:0] a);
		logic [AW-1:0] acc;
		logic [AW-1:0] sh;
		acc = AW'((AW'(x) + AW'(xp)) * AW'(b)) + AW'(AW'(yp) * AW'(a));
		sh = acc >> `EED_COEF_FRAC;
		return (sh > AW'({DW{1'b1}})) ? {DW{1'b1}} : sh[DW-1:0];
	endfunction

	// ----------------------------------------------------------------------
	// register access
	// ----------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			ratio_q <= `EED_RATIO_RST;
			filt_en_q <= 1'b0;
			lowpass_numerator_coeff_q <= `EED_NUM_RST;
			lowpass_feedback_coeff_q <= `EED_FB_RST;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				`EED_OFS_RATIO: ratio_q <= reg_wdata_i[5:0];
				`EED_OFS_CTRL: filt_en_q <= reg_wdata_i[`EED_CTRL_FILT_BIT];
				`EED_OFS_NUM: lowpass_numerator_coeff_q <= reg_wdata_i;
				`EED_OFS_FB: lowpass_feedback_coeff_q <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// overrun: a new decimated sample while the previous one is still pending;
	// a write to status clears it, but a same-cycle set wins
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			ovr_q <= 1'b0;
		else if (dec_valid_q && st_q != eed_pkg::EED_IDLE)
			ovr_q <= 1'b1;
		else if (reg_wr_i && reg_addr_i == `EED_OFS_STATUS
			&& reg_wdata_i[`EED_STAT_OVR_BIT])
			ovr_q <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			rdata_q <= '0;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				`EED_OFS_RATIO: rdata_q <= DW'(ratio_q);
				`EED_OFS_CTRL: rdata_q <= DW'(filt_en_q);
				`EED_OFS_NUM: rdata_q <= lowpass_numerator_coeff_q;
				`EED_OFS_FB: rdata_q <= lowpass_feedback_coeff_q;
				`EED_OFS_STATUS: rdata_q <= {DW'(level) << 8}
					| DW'({st_q != eed_pkg::EED_IDLE, ovr_q});
				`EED_OFS_LAST: rdata_q <= last_q;
				`EED_OFS_PEAK: rdata_q <= peak_q;
				default: rdata_q <= '0;
			endcase
		end
		else
			rdata_q <= '0;
	end

	assign reg_rdata_o = rdata_q;

	// ----------------------------------------------------------------------
	// sample tick, rectifier and peak extractor
	// ----------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i || tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + TW'(1);
	end

	assign tick = (tick_cnt_q == TW'(SAMPLE_CYCLES-1));
	assign mag = rectify(bp_sample_i);
	assign dec_max = (mag > peak_q) ? mag : peak_q;

	// ratio 0 is treated like 1: every sample wraps
	assign wrap = tick && (7'(cnt_q) + 7'(1) >= 7'(ratio_q));

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			cnt_q <= '0;
		else if (wrap)
			cnt_q <= '0;
		else if (tick)
			cnt_q <= cnt_q + 6'(1);
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i || wrap)
			peak_q <= '0;
		else if (tick && mag > peak_q)
			peak_q <= mag;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			clear_q <= 1'b0;
			dec_valid_q <= 1'b0;
			dec_q <= '0;
		end
		else
		begin
			clear_q <= wrap;
			dec_valid_q <= wrap;
			if (wrap)
				dec_q <= dec_max;
		end
	end

	assign clear_o = clear_q;

	// ----------------------------------------------------------------------
	// low-pass filter and push toward the fifo
	// ----------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			st_q <= eed_pkg::EED_IDLE;
		else
		begin
			case (st_q)
				eed_pkg::EED_IDLE:
					if (dec_valid_q)
						st_q <= filt_en_q ? eed_pkg::EED_CALC : eed_pkg::EED_PUSH;
				eed_pkg::EED_CALC: st_q <= eed_pkg::EED_PUSH;
				eed_pkg::EED_PUSH:
					if (push_ready)
						st_q <= eed_pkg::EED_IDLE;
				default: st_q <= eed_pkg::EED_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			x_prev_q <= '0;
			y_q <= '0;
			push_data_q <= '0;
			last_q <= '0;
		end
		else if (st_q == eed_pkg::EED_IDLE && dec_valid_q)
		begin
			push_data_q <= dec_q;
			last_q <= dec_q;
		end
		else if (st_q == eed_pkg::EED_CALC)
		begin
			// filter state moves once per decimated sample only
			y_q <= iir(push_data_q, x_prev_q, y_q, lowpass_numerator_coeff_q,
				lowpass_feedback_coeff_q);
			push_data_q <= iir(push_data_q, x_prev_q, y_q, lowpass_numerator_coeff_q,
				lowpass_feedback_coeff_q);
			x_prev_q <= push_data_q;
		end
	end

	eed_fifo #(
		.WIDTH(DW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_valid_i(st_q == eed_pkg::EED_PUSH),
		.in_ready_o(push_ready),
		.in_data_i(push_data_q),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(out_data_o),
		.level_o(level)
	);

	// ----------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------
	sequence s_filt_start;
		st_q == eed_pkg::EED_IDLE && dec_valid_q && filt_en_q;
	endsequence

	sequence s_filt_steps;
		##1 st_q == eed_pkg::EED_CALC ##1 st_q == eed_pkg::EED_PUSH;
	endsequence

	property p_wrap_clear;
		@(posedge clk_i) disable iff (reset_i)
		wrap |=> clear_o && cnt_q == 6'h00 ##1 !clear_o;
	endproperty
	a_wrap_clear: assert property (p_wrap_clear) else $error("clear pulse wrong");

	property p_peak_zero;
		@(posedge clk_i) disable iff (reset_i)
		clear_o |-> peak_q == '0;
	endproperty
	a_peak_zero: assert property (p_peak_zero) else $error("peak not cleared");

	property p_peak_hold;
		@(posedge clk_i) disable iff (reset_i)
		tick && !wrap && mag <= peak_q |=> $stable(peak_q);
	endproperty
	a_peak_hold: assert property (p_peak_hold) else $error("peak changed");

	property p_peak_rise;
		@(posedge clk_i) disable iff (reset_i)
		tick && !wrap && mag > peak_q |=> peak_q == $past(mag);
	endproperty
	a_peak_rise: assert property (p_peak_rise) else $error("peak missed");

	property p_capture;
		@(posedge clk_i) disable iff (reset_i)
		wrap |=> dec_valid_q && dec_q == $past(dec_max);
	endproperty
	a_capture: assert property (p_capture) else $error("bad capture");

	// judged on the registered results, so a broken wrap compare still shows
	property p_no_early;
		@(posedge clk_i) disable iff (reset_i)
		tick && 7'(cnt_q) + 7'(1) < 7'(ratio_q) |=> !clear_o && cnt_q != 6'h00;
	endproperty
	a_no_early: assert property (p_no_early) else $error("early wrap");

	property p_count_step;
		@(posedge clk_i) disable iff (reset_i)
		tick && !wrap |=> cnt_q == $past(cnt_q) + 6'(1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count step");

	property p_rectify;
		@(posedge clk_i) disable iff (reset_i)
		bp_sample_i[DW-1] |-> mag == DW'(-bp_sample_i);
	endproperty
	a_rectify: assert property (p_rectify) else $error("bad magnitude");

	property p_filt_seq;
		@(posedge clk_i) disable iff (reset_i)
		s_filt_start |-> s_filt_steps;
	endproperty
	a_filt_seq: assert property (p_filt_seq) else $error("filter steps");

	property p_raw_path;
		@(posedge clk_i) disable iff (reset_i)
		st_q == eed_pkg::EED_IDLE && dec_valid_q && !filt_en_q
			|=> st_q == eed_pkg::EED_PUSH && push_data_q == $past(dec_q);
	endproperty
	a_raw_path: assert property (p_raw_path) else $error("raw path");

endmodule

`default_nettype wire

//--- dv/eed_drain_model.sv
// eed_drain_model.sv: stand-in for whatever reads the decimator output fifo.
// assumes the decimator's clock and synchronous reset.
`timescale 1ns/1ns
`default_nettype none

module eed_drain_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// 0 always ready, 1 random stalls, 2 held off
	input wire logic [1:0] mode_i,
	// drain handshake
	output logic ready_o
);
	// ----------------------------------------------------------------------
	// ready generation
	// ----------------------------------------------------------------------
	// ready only changes right after an edge, like a real reader
	always_ff @(posedge clk_i)
	begin
		if (reset_i || mode_i == 2'h2)
			ready_o <= 1'b0;
		else
			ready_o <= (mode_i == 2'h0) || ($urandom_range(0, 1) == 0);
	end
endmodule

`default_nettype wire

//--- dv/test_echo_envelope_decimator_lowpass.sv
// test_echo_envelope_decimator_lowpass.sv: self-checking bench for eed_decimator.
// assumes logic/ design files and the drain model; sample tick cut to 4 cycles.
`timescale 1ns/1ns
`default_nettype none

module test_echo_envelope_decimator_lowpass;
	localparam int SC = 4;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic signed [15:0] bp_sample_i = 16'sh0000;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic clear_o;
	logic out_valid_o;
	logic out_ready_i;
	logic [15:0] out_data_o;
	logic [1:0] mode = 2'h0;
	logic rd_pend = 1'b0;
	logic [31:0] rq[$];
	logic [15:0] oq[$];
	logic [15:0] xp = 16'h0000;
	logic [15:0] yp = 16'h0000;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;

	eed_decimator #(.SAMPLE_CYCLES(SC)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
		.bp_sample_i(bp_sample_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.clear_o(clear_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
		.out_data_o(out_data_o));
	eed_drain_model i_drain (.clk_i(clk_i), .reset_i(reset_i), .mode_i(mode),
		.ready_o(out_ready_i));

	always #5 clk_i = ~clk_i;

	// ----------------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// strobes rise one edge after entry, so back-to-back calls never collide
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		rq.push_back({m, e});
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
	endtask

	task automatic wait_clear(output int n);
		n = 0;
		@(posedge clk_i);
		while (clear_o !== 1'b1 && n < 400)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 400)
			check(16'h0000, 16'hDEAD);
	endtask

	// unsigned filter model, state kept by the caller
	function automatic logic [15:0] lpf(input logic [15:0] x);
		logic [47:0] s;
		s = ((48'(x) + 48'(xp)) * 48'h0E09 + 48'(yp) * 48'h63EF) >> 15;
		lpf = (s > 48'h00FFFF) ? 16'hFFFF : s[15:0];
	endfunction

	// ----------------------------------------------------------------------
	// result watcher
	// ----------------------------------------------------------------------
	always @(posedge clk_i)
	begin
		rd_pend <= reg_rd_i;
		if (rd_pend && rq.size() > 0)
		begin
			check(reg_rdata_o & rq[0][31:16], rq[0][15:0]);
			void'(rq.pop_front());
		end
		if (out_valid_o === 1'b1 && out_ready_i === 1'b1 && oq.size() > 0)
			check(out_data_o, oq.pop_front());
		cyc++;
		if (cyc > 20000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------------
	initial
	begin
		int n;
		logic [15:0] v;
		logic [15:0] y;
		logic [7:0] rl[4];
		rl = '{8'h01, 8'h3F, 8'h19, 8'h32};
		void'($urandom(97));
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(4'h0, 16'h0019, 16'hFFFF);
		rd(4'h1, 16'h0000, 16'hFFFF);
		rd(4'h2, 16'h04D7, 16'hFFFF);
		rd(4'h3, 16'h7652, 16'hFFFF);
		wr(4'h9, 16'hFFFF);
		rd(4'h9, 16'h0000, 16'hFFFF);
		wr(4'h0, 16'hFFFF);
		rd(4'h0, 16'h003F, 16'hFFFF);
		// period between clear pulses at the ratio boundaries
		foreach (rl[i])
		begin
			wr(4'h0, {8'h00, rl[i]});
			wait_clear(n);
			wait_clear(n);
			check(16'(n + 1), 16'(rl[i] * SC));
		end
		// raw path, both signs; notes lag one period so stale words are skipped
		wr(4'h0, 16'h0019);
		wait_clear(n);
		for (int i = 0; i < 6; i++)
		begin
			v = 16'($urandom_range(1, 32767));
			bp_sample_i <= (i % 2) ? -v : v;
			// a smaller value later in the period must not displace the held peak
			repeat (50) @(posedge clk_i);
			bp_sample_i <= (i % 2) ? -(v >> 1) : (v >> 1);
			wait_clear(n);
			oq.push_back(v);
		end
		rd(4'h5, v, 16'hFFFF);
		rd(4'h6, v >> 1, 16'hFFFF);
		// fill until the fifo refuses, then drain
		v = 16'($urandom_range(1, 32767));
		bp_sample_i <= v;
		wait_clear(n);
		wait_clear(n);
		mode <= 2'h2;
		repeat (20) wait_clear(n);
		// full fifo: level 16, push stuck so busy, overrun set
		rd(4'h4, 16'h1003, 16'h1F03);
		repeat (16) oq.push_back(v);
		mode <= 2'h0;
		for (n = 0; n < 200 && out_valid_o !== 1'b0; n++)
			@(posedge clk_i);
		check(16'(oq.size()), 16'h0000);
		wr(4'h4, 16'h0001);
		rd(4'h4, 16'h0000, 16'h0001);
		// filter path; zero input first keeps the filter state at zero
		bp_sample_i <= 16'sh0000;
		wr(4'h0, 16'h001A);
		wr(4'h2, 16'h0E09);
		wr(4'h3, 16'h63EF);
		rd(4'h2, 16'h0E09, 16'hFFFF);
		wait_clear(n);
		wait_clear(n);
		repeat (4) @(posedge clk_i);
		wr(4'h1, 16'h0001);
		mode <= 2'h1;
		wait_clear(n);
		for (int i = 0; i < 5; i++)
		begin
			v = 16'($urandom_range(1, 32767));
			bp_sample_i <= (i % 2) ? -v : v;
			wait_clear(n);
			y = lpf(v);
			xp = v;
			yp = y;
			oq.push_back(y);
		end
		wait_clear(n);
		repeat (40) @(posedge clk_i);
		check(16'(oq.size() + rq.size()), 16'h0000);
		give_verdict();
	end
endmodule

`default_nettype wire
